//--- hw/aimg_ramp.sv
// Trapezoidal speed ramp and position counter of one axis.
`timescale 1ns/1ns
module aimg_ramp
  import aimg_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [aimg_pkg::SPD_W-1:0] target,
  input wire logic dir,
  input wire logic jump,
  input wire logic hard_stop,
  input wire logic zero_pos,
  input wire logic [aimg_pkg::SPD_W-1:0] up_rate,
  input wire logic [aimg_pkg::SPD_W-1:0] down_rate,
  output logic [aimg_pkg::SPD_W-1:0] speed,
  output logic at_rest,
  output logic step,
  output logic step_dir,
  output logic [31:0] position
);

  typedef struct packed {
    logic [SPD_W-1:0] speed;
    logic [ACC_W-1:0] racc;
    logic [ACC_W-1:0] pacc;
    logic cur_dir;
    logic at_rest;
    logic step;
    logic [31:0] position;
  } aimg_ramp_t;

  aimg_ramp_t r;
  aimg_ramp_t next_r;
  logic [SPD_W-1:0] want;
  logic [ACC_W-1:0] rsum;
  logic [ACC_W-1:0] psum;

  // A reversal first ramps to zero, or drops to zero at once under jump, then flips the direction at rest.
  // One speed step per clock at most, so rates above the clock rate saturate.
  always_comb
  begin
    next_r = r;
    want = (dir != r.cur_dir && r.speed != '0) ? '0 : target;
    rsum = ACC_W'(r.racc + ((r.speed < want) ? ACC_W'(up_rate) : ACC_W'(down_rate)));
    psum = ACC_W'(r.pacc + ACC_W'(r.speed));
    next_r.step = 1'b0;
    if (r.speed == '0)
      next_r.cur_dir = dir;
    if (hard_stop)
    begin
      next_r.speed = '0; // RQ15
      next_r.racc = '0;
    end
    else if (jump)
      next_r.speed = want;
    else if (r.speed != want)
    begin
      if (rsum >= CLK_HZ)
      begin
        next_r.racc = rsum - CLK_HZ;
        next_r.speed = (r.speed < want) ? SPD_W'(r.speed + 1'b1) : SPD_W'(r.speed - 1'b1);
      end
      else
        next_r.racc = rsum;
    end
    else
      next_r.racc = '0;
    // Position advances one count each time the speed accumulator wraps.
    if (psum >= CLK_HZ)
    begin
      next_r.pacc = psum - CLK_HZ;
      next_r.step = 1'b1;
      next_r.position = r.cur_dir ? 32'(r.position - 32'h1) : 32'(r.position + 32'h1);
    end
    else
      next_r.pacc = psum;
    if (zero_pos)
    begin
      next_r.position = 32'h0; // RQ13
      next_r.pacc = '0;
    end
    next_r.at_rest = (next_r.speed == '0);
  end

  // Ramp state register.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r <= '0;
      r.at_rest <= 1'b1;
    end
    else
      r <= next_r;
  end

  assign speed = r.speed;
  assign at_rest = r.at_rest;
  assign step = r.step;
  assign step_dir = r.cur_dir;
  assign position = r.position;

  hard_stop_zero_a: assert property (@(posedge clk) disable iff (!rst_n) hard_stop |=> r.speed == '0) // RQ15
    else $error("speed not zero after hard stop");

endmodule : aimg_ramp

//--- hw/aimg_sync.sv
// Two-stage synchroniser for the switch, index and general inputs.
`timescale 1ns/1ns
module aimg_sync #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } aimg_sync_t;

  aimg_sync_t r;
  aimg_sync_t next_r;

  // The first stage feeds only the second stage.
  always_comb
  begin
    next_r.s1 = d;
    next_r.s2 = r.s1;
  end

  // Both stages clear under reset.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      r <= '0;
    else
      r <= next_r;
  end

  assign q = r.s2;

endmodule : aimg_sync

//--- hw/aimg_top.sv
// Axis input guard: limits, homing sequences, abort and input read-back behind APB.
//
// What this block does
// RQ1: An active forward limit blocks forward motion at once.
// RQ2: An active reverse limit blocks reverse motion at once.
// RQ3: A limit hit during motion gives a ramped stop at the deceleration rate.
// RQ4: After a limit stop the drive stays enabled and holds position.
// RQ5: Either limit activating raises the limit handler request.
// RQ6: Begin toward an active limit is refused with error code 022.
// RQ7: Limit status reads 0 when active, 1 when inactive.
// RQ8: Active-low config: open input reads 0, grounded 1; active-high inverts.
// RQ9: Every home input transition is seen; polarity setting maps voltage to logic.
// RQ10: Edge seek slews until home changes, then decelerates; direction from home state.
// RQ11: Index seek slews until index rises, then decelerates; home ignored.
// RQ12: Combined homing reverses after first stop and creeps at 256 counts/s.
// RQ13: On second home change creep forward to index, stop, zero position.
// RQ14: Home state reads 0 when logically low, 1 when high.
// RQ15: Abort transition stops motion commands at once without ramp.
// RQ16: Abort turns the motor off if off-on-error is set, else servo stop.
// RQ17: Abort transition terminates every running program.
// RQ18: Software should set a high deceleration before edge seek.
// RQ19: General inputs are readable as a port and per bit.
// RQ20: Amplifier enable is high while enabled, low when motor off.
// RQ21: Limit, home, abort and index inputs are synchronised before use.
//
// The APB register port and the address map were decided locally.
`timescale 1ns/1ns
module aimg_top #(
  parameter int GP_W = 3
) (
  input wire logic MCLK,
  input wire logic RESETN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [aimg_pkg::ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic FWD_LIMIT_IN,
  input wire logic REV_LIMIT_IN,
  input wire logic HOME_IN,
  input wire logic ABORT_IN,
  input wire logic INDEX_IN,
  input wire logic [GP_W-1:0] GP_IN,
  output logic AMP_ENABLE_OUT,
  output logic LIMIT_HANDLER_REQ,
  output logic PROGRAM_ABORT,
  output logic STEP_OUT,
  output logic DIR_OUT
);
  import aimg_pkg::*;

  // ****************************************
  // State record
  // ****************************************
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic lim_pol_high;
    logic home_inv;
    logic off_on_err;
    logic motor_off;
    logic [SPD_W-1:0] up_rate;
    logic [SPD_W-1:0] down_rate;
    logic [SPD_W-1:0] slew;
    logic [SPD_W-1:0] target;
    logic cmd_dir;
    logic jump;
    logic hard_stop;
    logic zero_pos;
    logic hm_zero_armed;
    aimg_state_t state;
    logic [7:0] err;
    logic handler_pend;
    logic abort_seen;
    logic prog_abort;
    logic [1:0] settle;
    logic home_prev;
    logic index_prev;
    logic abort_prev;
    logic fwd_prev;
    logic rev_prev;
    logic amp_en;
  } aimg_top_t;

  aimg_top_t r;
  aimg_top_t next_r;
  logic [GP_W+4:0] sy;
  logic [SPD_W-1:0] speed;
  logic at_rest;
  logic step;
  logic step_dir;
  logic [31:0] position;
  logic fwd_state;
  logic rev_state;
  logic fwd_act;
  logic rev_act;
  logic home_state;
  logic armed;
  logic abort_edge;
  logic index_rise;
  logic home_chg;
  logic first;
  logic wr;
  logic do_begin;
  logic bdir;
  logic [31:0] rdata;

  // True when the offset names a register of this block.
  function automatic logic addr_known(input logic [ADDR_W-1:0] a);
    addr_known = (a == ADDR_CTRL) || (a == ADDR_CMD) || (a == ADDR_UP_RATE) || (a == ADDR_DOWN_RATE) ||
                 (a == ADDR_SLEW) || (a == ADDR_STATUS) || (a == ADDR_POSITION) || (a == ADDR_INPUT_PORT);
  endfunction : addr_known

  // ****************************************
  // Input conditioning
  // ****************************************
  // All switch and general input pins pass the synchroniser before any logic looks at them.
  aimg_sync #(
    .W(GP_W + 5)
  ) u_sync (
    .clk(MCLK),
    .rst_n(RESETN),
    .d({GP_IN, INDEX_IN, ABORT_IN, HOME_IN, REV_LIMIT_IN, FWD_LIMIT_IN}), // RQ21
    .q(sy)
  );

  // Limit state is 0 when active; open inputs read 0 in active-low mode.
  assign fwd_state = r.lim_pol_high ? sy[0] : ~sy[0]; // RQ8
  assign rev_state = r.lim_pol_high ? sy[1] : ~sy[1]; // RQ8
  assign fwd_act = ~fwd_state; // RQ7
  assign rev_act = ~rev_state; // RQ7
  assign home_state = sy[2] ^ r.home_inv; // RQ14
  // Edges wait until the synchroniser has filled, so reset gives no false abort.
  assign armed = (r.settle == SETTLE_DONE);
  assign abort_edge = armed & (sy[3] ^ r.abort_prev);
  assign index_rise = armed & sy[4] & ~r.index_prev;
  assign home_chg = armed & (home_state ^ r.home_prev); // RQ9

  // ****************************************
  // APB decode and read data
  // ****************************************
  // One wait state: PREADY rises in the second access cycle.
  assign first = PSEL & PENABLE & ~r.pready;
  assign wr = PSEL & PENABLE & r.pready & PWRITE;
  assign do_begin = wr && (PADDR == ADDR_CMD) && PWDATA[CMD_BEGIN];

  // Read mux of all registers; the command register ADDR_CMD reads 0.
  always_comb
  begin
    rdata = 32'h0;
    unique case (PADDR)
      ADDR_CTRL: rdata = {28'h0, r.motor_off, r.off_on_err, r.home_inv, r.lim_pol_high};
      ADDR_UP_RATE: rdata = {8'h0, r.up_rate};
      ADDR_DOWN_RATE: rdata = {8'h0, r.down_rate};
      ADDR_SLEW: rdata = {8'h0, r.slew};
      ADDR_STATUS: rdata = {16'h0, r.err, 1'b0, r.abort_seen, r.handler_pend, r.amp_en,
                            ~at_rest | (r.state != ST_IDLE), home_state, rev_state, fwd_state}; // RQ7 RQ14
      ADDR_POSITION: rdata = position;
      ADDR_INPUT_PORT: rdata = {{(32 - GP_W){1'b0}}, sy[GP_W+4:5]}; // RQ19
      default: rdata = 32'h0;
    endcase
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    next_r = r;
    bdir = 1'b0;
    next_r.pready = first;
    next_r.pslverr = first & ~addr_known(PADDR);
    next_r.prdata = (first & ~PWRITE) ? rdata : 32'h0;
    next_r.prog_abort = 1'b0;
    next_r.zero_pos = 1'b0;
    next_r.hard_stop = r.motor_off;
    next_r.settle = armed ? r.settle : 2'(r.settle + 2'h1);
    next_r.home_prev = home_state;
    next_r.index_prev = sy[4];
    next_r.abort_prev = sy[3];
    next_r.fwd_prev = fwd_act;
    next_r.rev_prev = rev_act;
    // Register writes take effect at the edge that completes the access.
    if (wr)
    begin
      unique case (PADDR)
        ADDR_CTRL:
        begin
          next_r.lim_pol_high = PWDATA[CTRL_LIM_POL_HIGH];
          next_r.home_inv = PWDATA[CTRL_HOME_INV];
          next_r.off_on_err = PWDATA[CTRL_OFF_ON_ERR];
          next_r.motor_off = PWDATA[CTRL_MOTOR_OFF];
        end
        ADDR_UP_RATE: next_r.up_rate = PWDATA[SPD_W-1:0];
        ADDR_DOWN_RATE: next_r.down_rate = PWDATA[SPD_W-1:0];
        ADDR_SLEW: next_r.slew = PWDATA[SPD_W-1:0];
        ADDR_STATUS:
        begin
          if (PWDATA[ST_HANDLER])
            next_r.handler_pend = 1'b0;
          if (PWDATA[ST_ABORT])
            next_r.abort_seen = 1'b0;
          if (PWDATA[ST_ERR_CLR])
            next_r.err = 8'h0;
        end
        default:
        begin
        end
      endcase
    end
    // A new limit activation wins over a clear in the same cycle.
    if ((fwd_act & ~r.fwd_prev) | (rev_act & ~r.rev_prev))
      next_r.handler_pend = armed | r.handler_pend; // RQ5
    // Motion sequencer.
    unique case (r.state)
      ST_IDLE:
      begin
        next_r.target = '0;
        next_r.jump = 1'b0;
        if (do_begin && !r.motor_off)
        begin
          // Seek direction follows the home state: high seeks in reverse.
          bdir = (PWDATA[2:0] == MODE_JOG_REV) ||
                 (((PWDATA[2:0] == MODE_EDGE_SEEK) || (PWDATA[2:0] == MODE_HOME_SEQ)) && home_state); // RQ10
          if ((!bdir && fwd_act) || (bdir && rev_act))
            next_r.err = ERR_BEGIN_LIMIT; // RQ6
          else
          begin
            next_r.cmd_dir = bdir;
            next_r.target = r.slew;
            unique case (PWDATA[2:0])
              MODE_JOG_FWD, MODE_JOG_REV: next_r.state = ST_RUN;
              MODE_EDGE_SEEK: next_r.state = ST_EDGE;
              MODE_INDEX_SEEK: next_r.state = ST_INDEX; // RQ11
              MODE_HOME_SEQ: next_r.state = ST_HM_SEEK;
              default: next_r.target = '0;
            endcase
          end
        end
      end
      ST_RUN: next_r.target = r.slew;
      ST_EDGE, ST_HM_SEEK, ST_INDEX:
      begin
        next_r.target = r.slew;
        // Index seek watches only the index; the other two watch the home state.
        if ((r.state == ST_INDEX) ? index_rise : home_chg)
        begin
          next_r.target = '0; // RQ10 RQ11
          next_r.state = (r.state == ST_HM_SEEK) ? ST_HM_STOP1 : ST_STOPPING;
        end
      end
      ST_HM_STOP1:
      begin
        if (at_rest)
        begin
          // Back toward the transition at creep speed, with no ramp.
          next_r.cmd_dir = ~r.cmd_dir; // RQ12
          next_r.target = HOME_CREEP_SPEED; // RQ12
          next_r.jump = 1'b1;
          next_r.state = ST_HM_BACK;
        end
      end
      ST_HM_BACK:
      begin
        if (home_chg)
        begin
          next_r.cmd_dir = 1'b0; // RQ13
          next_r.state = ST_HM_FWD;
        end
      end
      ST_HM_FWD:
      begin
        if (index_rise)
        begin
          next_r.jump = 1'b0;
          next_r.target = '0; // RQ13
          next_r.state = ST_STOPPING;
        end
      end
      ST_STOPPING:
      begin
        next_r.target = '0;
        next_r.jump = 1'b0;
        if (at_rest)
        begin
          next_r.state = ST_IDLE;
        end
      end
    endcase
    // Zero the position once the index stop of the combined sequence is at rest.
    if (r.state == ST_HM_FWD && index_rise)
      next_r.hm_zero_armed = 1'b1;
    else if (r.state == ST_IDLE)
      next_r.hm_zero_armed = 1'b0;
    next_r.zero_pos = r.hm_zero_armed && r.state == ST_STOPPING && at_rest; // RQ13
    // A limit ahead during motion ends it with the programmed ramp; the servo stays on.
    if (r.state != ST_IDLE && r.state != ST_STOPPING &&
        ((!next_r.cmd_dir && fwd_act) || (next_r.cmd_dir && rev_act)))
    begin
      next_r.state = ST_STOPPING; // RQ3
      next_r.jump = 1'b0;
    end
    if (r.state != ST_IDLE && wr && (PADDR == ADDR_CMD) && PWDATA[CMD_STOP])
      next_r.state = ST_STOPPING;
    // Forward or reverse demand toward an active limit is cut the same cycle.
    if ((!next_r.cmd_dir && fwd_act) || (next_r.cmd_dir && rev_act))
      next_r.target = '0; // RQ1 RQ2
    // Abort: no ramp, end programs, and drop the drive only with off-on-error.
    if (abort_edge)
    begin
      next_r.state = ST_IDLE; // RQ15
      next_r.target = '0;
      next_r.jump = 1'b0;
      next_r.hard_stop = 1'b1; // RQ15
      next_r.prog_abort = 1'b1; // RQ17
      next_r.abort_seen = 1'b1;
      if (r.off_on_err)
        next_r.motor_off = 1'b1; // RQ16
    end
    if (r.motor_off)
      next_r.state = ST_IDLE;
    // Limits never touch the drive enable; only motor-off does.
    next_r.amp_en = ~r.motor_off; // RQ4 RQ20
  end

  // State register; the drive is enabled after reset.
  always_ff @(posedge MCLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      r <= '0;
      r.state <= ST_IDLE;
      r.up_rate <= RATE_RESET;
      r.down_rate <= RATE_RESET;
      r.slew <= RATE_RESET;
      r.amp_en <= 1'b1;
    end
    else
      r <= next_r;
  end

  // ****************************************
  // Profile generator
  // ****************************************
  aimg_ramp u_ramp (
    .clk(MCLK),
    .rst_n(RESETN),
    .target(r.target),
    .dir(r.cmd_dir),
    .jump(r.jump),
    .hard_stop(r.hard_stop),
    .zero_pos(r.zero_pos),
    .up_rate(r.up_rate),
    .down_rate(r.down_rate),
    .speed(speed),
    .at_rest(at_rest),
    .step(step),
    .step_dir(step_dir),
    .position(position)
  );

  assign PRDATA = r.prdata;
  assign PREADY = r.pready;
  assign PSLVERR = r.pslverr;
  assign AMP_ENABLE_OUT = r.amp_en;
  assign LIMIT_HANDLER_REQ = r.handler_pend;
  assign PROGRAM_ABORT = r.prog_abort;
  assign STEP_OUT = step;
  assign DIR_OUT = step_dir;

  // ****************************************
  // Assertions
  // ****************************************
  fwd_block_a: assert property (@(posedge MCLK) disable iff (!RESETN) // RQ1
    (fwd_act && !r.cmd_dir && !abort_edge) |=> (r.target == '0 || r.cmd_dir))
    else $error("forward demand kept at active forward limit");
  rev_block_a: assert property (@(posedge MCLK) disable iff (!RESETN) // RQ2
    (rev_act && r.cmd_dir) |=> (r.target == '0 || !r.cmd_dir))
    else $error("reverse demand kept at active reverse limit");
  begin_refuse_a: assert property (@(posedge MCLK) disable iff (!RESETN) // RQ6
    (do_begin && r.state == ST_IDLE && !r.motor_off && !abort_edge && fwd_act && PWDATA[2:0] == MODE_JOG_FWD)
    |=> (r.err == ERR_BEGIN_LIMIT && r.state == ST_IDLE))
    else $error("begin toward limit not refused");
  limit_read_a: assert property (@(posedge MCLK) disable iff (!RESETN) // RQ7
    (first && !PWRITE && PADDR == ADDR_STATUS) |=> (PRDATA[0] == !$past(fwd_act) && PREADY))
    else $error("forward limit status reads wrong level");
  handler_set_a: assert property (@(posedge MCLK) disable iff (!RESETN) // RQ5
    (armed && fwd_act && !r.fwd_prev) |=> LIMIT_HANDLER_REQ)
    else $error("limit handler request not raised");
  abort_stop_a: assert property (@(posedge MCLK) disable iff (!RESETN) // RQ15
    abort_edge |=> (r.hard_stop && r.state == ST_IDLE) ##1 (speed == '0))
    else $error("abort did not stop without ramp");
  abort_off_a: assert property (@(posedge MCLK) disable iff (!RESETN) // RQ16
    (abort_edge && r.off_on_err) |-> ##2 !AMP_ENABLE_OUT)
    else $error("abort with off-on-error left drive on");
  abort_prog_a: assert property (@(posedge MCLK) disable iff (!RESETN) // RQ17
    abort_edge |=> PROGRAM_ABORT ##1 (!PROGRAM_ABORT || $past(abort_edge)))
    else $error("program abort pulse missing");
  creep_speed_a: assert property (@(posedge MCLK) disable iff (!RESETN) // RQ12
    (r.state == ST_HM_BACK && !rev_act && !fwd_act) |-> (r.target == HOME_CREEP_SPEED && r.jump))
    else $error("home approach not at creep speed");
  limit_servo_a: assert property (@(posedge MCLK) disable iff (!RESETN) // RQ4
    (fwd_act && !r.motor_off && !abort_edge) |=> AMP_ENABLE_OUT)
    else $error("limit dropped the drive");

endmodule : aimg_top

//--- inc/aimg_pkg.sv
// Shared constants, register map and state codes of the axis input motion guard.
package aimg_pkg;

  // ****************************************
  // Clock and widths
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS = 40;
  // Clock rate in Hz, used as the modulus of the rate accumulators.
  localparam logic [25:0] CLK_HZ = 26'(1000000000 / CLK_PERIOD_NS);
  localparam int unsigned SPD_W = 24;
  localparam int unsigned ACC_W = 26;
  localparam int unsigned ADDR_W = 8;
  localparam logic [1:0] SETTLE_DONE = 2'h3;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_CMD = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_UP_RATE = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_DOWN_RATE = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_SLEW = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_POSITION = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_INPUT_PORT = 8'h1c;

  // ****************************************
  // Field positions and values
  // ****************************************
  localparam int unsigned CTRL_LIM_POL_HIGH = 0;
  localparam int unsigned CTRL_HOME_INV = 1;
  localparam int unsigned CTRL_OFF_ON_ERR = 2;
  localparam int unsigned CTRL_MOTOR_OFF = 3;
  localparam int unsigned CMD_BEGIN = 8;
  localparam int unsigned CMD_STOP = 9;
  localparam int unsigned ST_HANDLER = 5;
  localparam int unsigned ST_ABORT = 6;
  localparam int unsigned ST_ERR_CLR = 7;
  localparam logic [2:0] MODE_JOG_FWD = 3'h0;
  localparam logic [2:0] MODE_JOG_REV = 3'h1;
  localparam logic [2:0] MODE_EDGE_SEEK = 3'h2;
  localparam logic [2:0] MODE_INDEX_SEEK = 3'h3;
  localparam logic [2:0] MODE_HOME_SEQ = 3'h4;
  // Error code 022 (decimal) for a begin toward an active limit.
  localparam logic [7:0] ERR_BEGIN_LIMIT = 8'h16;
  localparam logic [SPD_W-1:0] HOME_CREEP_SPEED = 24'h000100;
  localparam logic [SPD_W-1:0] RATE_RESET = 24'h000000;

  // ****************************************
  // Motion sequencer states
  // ****************************************
  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_RUN = 9'h002,
    ST_EDGE = 9'h004,
    ST_INDEX = 9'h008,
    ST_HM_SEEK = 9'h010,
    ST_HM_STOP1 = 9'h020,
    ST_HM_BACK = 9'h040,
    ST_HM_FWD = 9'h080,
    ST_STOPPING = 9'h100
  } aimg_state_t;

endpackage : aimg_pkg

//--- tb/aimg_switch_model.sv
// Limit, home, abort and index switch model for the axis guard bench.
`timescale 1ns/1ns
module aimg_switch_model (
  input wire logic clk,
  input wire logic [4:0] want,
  output logic [4:0] pins
);
  // ****
  // Pins
  // ****
  // Contacts move just after an edge, so the guard sees clean asynchronous levels.
  initial pins = 5'h00;
  always @(posedge clk)
  begin
    pins <= want;
  end
endmodule : aimg_switch_model

//--- tb/axis_input_motion_guard_tb_top.sv
// Self-checking bench of the axis input guard.
`timescale 1ns/1ns
module axis_input_motion_guard_tb_top;
  import aimg_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] e;} aimg_row_t;
  logic MCLK = 1'b0;
  logic RESETN = 1'b0;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0;
  logic [31:0] PRDATA;
  logic PREADY, PSLVERR, AMP_ENABLE_OUT, LIMIT_HANDLER_REQ, PROGRAM_ABORT;
  logic [4:0] want = 5'h00;
  logic [2:0] gp = 3'h5;
  logic [4:0] pins;
  logic [31:0] rd;
  logic er;
  int failures = 0;
  int compares = 0;
  int cyc = 0;
  aimg_row_t rows[9] = '{'{ADDR_CTRL, 0}, '{ADDR_CMD, 0}, '{ADDR_UP_RATE, 0}, '{ADDR_DOWN_RATE, 0},
    '{ADDR_SLEW, 0}, '{ADDR_STATUS, 32'h13}, '{ADDR_POSITION, 0}, '{ADDR_INPUT_PORT, 32'h5}, '{8'h20, 0}};
  always #20 MCLK = ~MCLK;
  aimg_switch_model aimg_switch_model_i (.clk(MCLK), .want(want), .pins(pins));
  aimg_top #(.GP_W(3)) aimg_top_i (.MCLK(MCLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .FWD_LIMIT_IN(pins[0]), .REV_LIMIT_IN(pins[1]), .HOME_IN(pins[2]), .ABORT_IN(pins[3]),
    .INDEX_IN(pins[4]), .GP_IN(gp), .AMP_ENABLE_OUT(AMP_ENABLE_OUT),
    .LIMIT_HANDLER_REQ(LIMIT_HANDLER_REQ), .PROGRAM_ABORT(PROGRAM_ABORT), .STEP_OUT(), .DIR_OUT());
  // ****
  // Tasks
  // ****
  // One APB transfer; the request is held until PREADY is sampled high.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge MCLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    do @(posedge MCLK); while (PREADY !== 1'b1);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      failures++;
    end
  endtask : chk
  task finish_test;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test
  // ****
  // Sequence
  // ****
  // A hang counts as a mismatch; the whole run needs well under a thousand cycles.
  always @(posedge MCLK)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      failures++;
      finish_test();
    end
  end
  initial
  begin
    repeat (3) @(posedge MCLK);
    chk("amp in reset", 1, AMP_ENABLE_OUT);
    repeat (2) @(posedge MCLK);
    RESETN <= 1'b1;
    repeat (4) @(posedge MCLK);
    foreach (rows[i])
    begin
      apb(1'b0, rows[i].a, 32'h0);
      chk("reg", rows[i].e, rd);
      chk("slverr", rows[i].a == 8'h20, er);
    end
    gp <= 3'h2;
    repeat (3) @(posedge MCLK);
    apb(1'b0, ADDR_INPUT_PORT, 0);
    chk("inputs", 32'h2, rd);
    // Active-low limits: a high pin is an active switch.
    want <= 5'h01;
    repeat (6) @(posedge MCLK);
    apb(1'b0, ADDR_STATUS, 0);
    chk("fwd state", 0, rd[0]);
    chk("handler", 1, LIMIT_HANDLER_REQ);
    apb(1'b1, ADDR_CMD, 32'h100);
    apb(1'b0, ADDR_STATUS, 0);
    chk("begin error", ERR_BEGIN_LIMIT, rd[15:8]);
    chk("no motion", 0, rd[3]);
    apb(1'b1, ADDR_CTRL, 32'h1);
    repeat (2) @(posedge MCLK);
    apb(1'b0, ADDR_STATUS, 0);
    chk("fwd high pol", 1, rd[0]);
    // Edge seek forward from a low home state; a home change must end the move.
    apb(1'b1, ADDR_UP_RATE, 32'hffffff);
    apb(1'b1, ADDR_DOWN_RATE, 32'hffffff);
    apb(1'b1, ADDR_SLEW, 32'h10);
    apb(1'b1, ADDR_CMD, 32'h102);
    apb(1'b0, ADDR_STATUS, 0);
    chk("seek moving", 1, rd[3]);
    want <= 5'h05;
    repeat (60) @(posedge MCLK);
    apb(1'b0, ADDR_STATUS, 0);
    chk("seek stopped", 0, rd[3]);
    // Abort with off-on-error turns the drive off and ends programs.
    apb(1'b1, ADDR_CTRL, 32'h4);
    want <= 5'h0d;
    for (int k = 0; k < 20 && PROGRAM_ABORT !== 1'b1; k++) @(posedge MCLK);
    chk("abort pulse", 1, PROGRAM_ABORT);
    repeat (3) @(posedge MCLK);
    chk("amp off", 0, AMP_ENABLE_OUT);
    apb(1'b0, ADDR_STATUS, 0);
    chk("abort seen", 1, rd[6]);
    finish_test();
  end
endmodule : axis_input_motion_guard_tb_top
